// ===== src/tld_consts.svh
`ifndef TLD_CONSTS_SVH
`define TLD_CONSTS_SVH

// register byte offsets
`define TLD_ADDR_CTRL     8'h00
`define TLD_ADDR_LIMIT    8'h04
`define TLD_ADDR_LEVEL    8'h08
`define TLD_ADDR_INFN_LO  8'h0C
`define TLD_ADDR_INFN_HI  8'h10
`define TLD_ADDR_OUTFN    8'h14
`define TLD_ADDR_STATUS   8'h18

// axi responses
`define TLD_RESP_OKAY     2'h0
`define TLD_RESP_SLVERR   2'h2

// terminal function codes
`define TLD_FN_LIMIT_EN   8'h28
`define TLD_FN_SEL_ONE    8'h29
`define TLD_FN_SEL_TWO    8'h2A
`define TLD_FN_ACTIVE     8'h0A
`define TLD_FN_DETECT     8'h07

// percentages and codes
`define TLD_PCT_MAX       8'hC8
`define TLD_LIMIT_OFF     8'hFF
`define TLD_LIMIT_RST     8'h96
`define TLD_LEVEL_RST     8'h64
`define TLD_TRQ_MAX       10'sh0C8
`define TLD_TRQ_MIN       10'sh338
`define TLD_ANALOG_FS     18'h003FF

// timing
`define TLD_CLK_MHZ       16'h0014
`define TLD_DECEL_HOLD_US 16'h0064
`define TLD_DECEL_HOLD_CYC (`TLD_DECEL_HOLD_US * `TLD_CLK_MHZ)

`endif

// ===== src/tld_pkg.sv
package tld_pkg;

	typedef enum logic [1:0] {
		TLD_SRC_QUAD   = 2'h0,
		TLD_SRC_BITS   = 2'h1,
		TLD_SRC_ANALOG = 2'h2,
		TLD_SRC_OPTION = 2'h3
	} tld_src_t;

	typedef logic [6:0][7:0] tld_infn_t;
	typedef logic [3:0][7:0] tld_quad_vals_t;

	// true when any terminal carrying the code is on in lvl
	function automatic logic tld_fn_hit(input tld_infn_t fn, input logic [6:0] lvl,
		input logic [7:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 7; i++) begin
			if (fn[i] == code && lvl[i]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

endpackage

// ===== src/tld_quadrant.sv
`timescale 1ns/1ps
`include "tld_consts.svh"

module tld_quadrant (
	// clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     srst_i,
	// drive state
	input  wire logic signed [15:0]       speed_i,
	input  wire logic signed [8:0]        torque_i,
	// limit sources
	input  tld_pkg::tld_src_t             src_i,
	input  tld_pkg::tld_quad_vals_t       limits_i,
	input  tld_pkg::tld_quad_vals_t       levels_i,
	input  wire logic [1:0]               sel_idx_i,
	input  wire logic [9:0]               analog_i,
	input  wire logic [7:0]               option_i,
	// selected values
	output logic [1:0]                    quad_o,
	output logic [7:0]                    mag_o,
	output logic [7:0]                    limit_o,
	output logic [7:0]                    level_o
);
	import tld_pkg::*;

	logic [1:0]  next_quad;
	logic [7:0]  next_mag;
	logic [7:0]  next_limit;
	logic [17:0] prod;

	always_comb begin
		next_quad = {torque_i[8], speed_i[15] ^ torque_i[8]};
		next_mag  = torque_i[8] ? 8'(-torque_i) : 8'(torque_i);
		// 0..10 V full scale onto 0..200 percent
		prod = 18'(analog_i) * 18'(`TLD_PCT_MAX);
		unique case (src_i)
			TLD_SRC_QUAD:   next_limit = limits_i[next_quad];
			// terminal pair picks one value for all quadrants
			TLD_SRC_BITS:   next_limit = limits_i[sel_idx_i];
			TLD_SRC_ANALOG: next_limit = 8'(prod / `TLD_ANALOG_FS);
			TLD_SRC_OPTION: next_limit = option_i;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			quad_o  <= 2'h0;
			mag_o   <= 8'h00;
			limit_o <= `TLD_LIMIT_OFF;
			level_o <= 8'h00;
		end else begin
			quad_o  <= next_quad;
			mag_o   <= next_mag;
			limit_o <= next_limit;
			level_o <= levels_i[next_quad];
		end
	end

endmodule

// ===== src/tld_top.sv
// Summary of operation
// - limit-enable terminal on applies selected limit; the code applies it only while speed_mode_i is high
// - no limit-enable terminal means always limited; the code limits only while speed_mode_i is high
// - limit-enable assigned but off disables limiting
// - function 10 output high while limiting
// - source 0 quad, 1 bits, 2 analog, 3 option
// - quad source uses per-quadrant limit values
// - bit source picks value for all quadrants
// - limit is 0..200 percent or disable code
// - analog 0..10 V maps to 0..200 percent
// - option source takes limit from option board
// - hold setting pauses deceleration on limit change
// - input function 40 is limit enable level
// - output function 07 flags torque detection
// - polarity selects over or under detection
// - detection level chosen by present quadrant
// - timing selects running or constant speed only
// - torque monitor clamped to plus minus 200
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "tld_consts.svh"

module tld_top (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               srst_i,
	// axi4-lite write
	input  wire logic [7:0]         s_axi_awaddr_i,
	input  wire logic               s_axi_awvalid_i,
	output logic                    s_axi_awready_o,
	input  wire logic [31:0]        s_axi_wdata_i,
	input  wire logic [3:0]         s_axi_wstrb_i,
	input  wire logic               s_axi_wvalid_i,
	output logic                    s_axi_wready_o,
	output logic [1:0]              s_axi_bresp_o,
	output logic                    s_axi_bvalid_o,
	input  wire logic               s_axi_bready_i,
	// axi4-lite read
	input  wire logic [7:0]         s_axi_araddr_i,
	input  wire logic               s_axi_arvalid_i,
	output logic                    s_axi_arready_o,
	output logic [31:0]             s_axi_rdata_o,
	output logic [1:0]              s_axi_rresp_o,
	output logic                    s_axi_rvalid_o,
	input  wire logic               s_axi_rready_i,
	// multifunction terminals
	input  wire logic [6:0]         in_term_i,
	output logic [2:0]              out_term_o,
	// drive side
	input  wire logic signed [9:0]  torque_est_i,
	input  wire logic signed [15:0] speed_i,
	input  wire logic               run_i,
	input  wire logic               accel_i,
	input  wire logic               decel_i,
	input  wire logic               speed_mode_i,
	input  wire logic [9:0]         analog_voltage_input_i,
	input  wire logic [7:0]         option_limit_i,
	// results
	output logic                    limiting_active_output_o,
	output logic                    torque_detect_output_o,
	output logic                    decel_hold_o,
	output logic [7:0]              torque_limit_o,
	output logic signed [8:0]       torque_estimate_monitor_o
);
	import tld_pkg::*;

	// settings
	tld_src_t       src_q;
	logic           decel_hold_setting;
	logic           detect_polarity_setting;
	logic           detect_timing_setting;
	tld_quad_vals_t limit_val;
	tld_quad_vals_t level_val;
	tld_infn_t      in_fn;
	logic [2:0][7:0] out_fn;

	// bus state
	logic           aw_got;
	logic           w_got;
	logic [7:0]     waddr_q;
	logic [31:0]    wdata_q;
	logic [3:0]     wstrb_q;
	logic           do_write;
	logic           wr_ok;
	logic [31:0]    rd_word;
	logic           rd_ok;

	// datapath
	logic [6:0]     term_m;
	logic [6:0]     term_s;
	logic signed [8:0] torque_c;
	logic [1:0]     q_quad;
	logic [7:0]     q_mag;
	logic [7:0]     q_limit;
	logic [7:0]     q_level;
	logic           le_assigned;
	logic           le_level;
	logic [1:0]     sel_idx;
	logic           apply;
	logic           det_gate;
	logic           next_active;
	logic           next_detect;
	logic [15:0]    hold_cnt;

	// a pin level may change anywhere in the period; only term_s is read
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			term_m <= 7'h00;
			term_s <= 7'h00;
		end else begin
			term_m <= in_term_i;
			term_s <= term_m;
		end
	end

	// ---- axi4-lite write channel ----
	assign do_write = aw_got && w_got;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			aw_got          <= 1'b0;
			w_got           <= 1'b0;
			waddr_q         <= 8'h00;
			wdata_q         <= 32'h0000_0000;
			wstrb_q         <= 4'h0;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= `TLD_RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				s_axi_awready_o <= 1'b0;
				aw_got          <= 1'b1;
				waddr_q         <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				s_axi_wready_o <= 1'b0;
				w_got          <= 1'b1;
				wdata_q        <= s_axi_wdata_i;
				wstrb_q        <= s_axi_wstrb_i;
			end
			if (do_write) begin
				aw_got         <= 1'b0;
				w_got          <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_ok ? `TLD_RESP_OKAY : `TLD_RESP_SLVERR;
			end
			// ready returns only after the response, so one write at a time
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o  <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	always_comb begin
		case ({waddr_q[7:2], 2'h0})
			`TLD_ADDR_CTRL, `TLD_ADDR_LIMIT, `TLD_ADDR_LEVEL, `TLD_ADDR_INFN_LO,
			`TLD_ADDR_INFN_HI, `TLD_ADDR_OUTFN, `TLD_ADDR_STATUS: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			src_q                   <= TLD_SRC_QUAD;
			decel_hold_setting      <= 1'b0;
			detect_polarity_setting <= 1'b0;
			detect_timing_setting   <= 1'b0;
			limit_val               <= {4{`TLD_LIMIT_RST}};
			level_val               <= {4{`TLD_LEVEL_RST}};
			in_fn                   <= '0;
			out_fn                  <= '0;
		end else if (do_write) begin
			case ({waddr_q[7:2], 2'h0})
				`TLD_ADDR_CTRL: begin
					if (wstrb_q[0]) begin
						src_q                   <= tld_src_t'(wdata_q[1:0]);
						decel_hold_setting      <= wdata_q[2];
						detect_polarity_setting <= wdata_q[3];
						detect_timing_setting   <= wdata_q[4];
					end
				end
				`TLD_ADDR_LIMIT: begin
					for (int i = 0; i < 4; i++) begin
						if (wstrb_q[i]) begin
							limit_val[i] <= wdata_q[8*i +: 8];
						end
					end
				end
				`TLD_ADDR_LEVEL: begin
					for (int i = 0; i < 4; i++) begin
						if (wstrb_q[i]) begin
							level_val[i] <= wdata_q[8*i +: 8];
						end
					end
				end
				`TLD_ADDR_INFN_LO: begin
					for (int i = 0; i < 4; i++) begin
						if (wstrb_q[i]) begin
							in_fn[i] <= wdata_q[8*i +: 8];
						end
					end
				end
				`TLD_ADDR_INFN_HI: begin
					for (int i = 0; i < 3; i++) begin
						if (wstrb_q[i]) begin
							in_fn[4+i] <= wdata_q[8*i +: 8];
						end
					end
				end
				`TLD_ADDR_OUTFN: begin
					for (int i = 0; i < 3; i++) begin
						if (wstrb_q[i]) begin
							out_fn[i] <= wdata_q[8*i +: 8];
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ---- axi4-lite read channel ----
	always_comb begin
		rd_ok = 1'b1;
		case ({s_axi_araddr_i[7:2], 2'h0})
			`TLD_ADDR_CTRL:    rd_word = {27'h0, detect_timing_setting,
				detect_polarity_setting, decel_hold_setting, src_q};
			`TLD_ADDR_LIMIT:   rd_word = limit_val;
			`TLD_ADDR_LEVEL:   rd_word = level_val;
			`TLD_ADDR_INFN_LO: rd_word = in_fn[3:0];
			`TLD_ADDR_INFN_HI: rd_word = {8'h00, in_fn[6:4]};
			`TLD_ADDR_OUTFN:   rd_word = {8'h00, out_fn};
			`TLD_ADDR_STATUS:  rd_word = {3'h0, torque_limit_o, q_quad, decel_hold_o,
				torque_detect_output_o, limiting_active_output_o,
				{7{torque_estimate_monitor_o[8]}}, torque_estimate_monitor_o};
			default: begin
				rd_word = 32'h0000_0000;
				rd_ok   = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= `TLD_RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rdata_o   <= rd_word;
			s_axi_rresp_o   <= rd_ok ? `TLD_RESP_OKAY : `TLD_RESP_SLVERR;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o  <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

	// ---- torque path ----
	always_comb begin
		// clamp estimate to the monitor range
		if (torque_est_i > `TLD_TRQ_MAX) begin
			torque_c = 9'(`TLD_TRQ_MAX);
		end else if (torque_est_i < `TLD_TRQ_MIN) begin
			torque_c = 9'(`TLD_TRQ_MIN);
		end else begin
			torque_c = torque_est_i[8:0];
		end
	end

	// select bit two is the high index bit
	assign sel_idx = {tld_fn_hit(in_fn, term_s, `TLD_FN_SEL_TWO),
		tld_fn_hit(in_fn, term_s, `TLD_FN_SEL_ONE)};

	tld_quadrant u_quadrant (
		.clk_i     (clk_i),
		.srst_i    (srst_i),
		.speed_i   (speed_i),
		.torque_i  (torque_c),
		.src_i     (src_q),
		.limits_i  (limit_val),
		.levels_i  (level_val),
		.sel_idx_i (sel_idx),
		.analog_i  (analog_voltage_input_i),
		.option_i  (option_limit_i),
		.quad_o    (q_quad),
		.mag_o     (q_mag),
		.limit_o   (q_limit),
		.level_o   (q_level)
	);

	always_comb begin
		// function 40 on any terminal marks the enable as assigned
		le_assigned = tld_fn_hit(in_fn, 7'h7F, `TLD_FN_LIMIT_EN);
		le_level    = tld_fn_hit(in_fn, term_s, `TLD_FN_LIMIT_EN);
		// enable follows the terminal only when one is assigned
		apply = (!le_assigned || le_level) && speed_mode_i;
		// disable code means no limit at all
		next_active = apply && (q_limit != `TLD_LIMIT_OFF) && (q_mag >= q_limit);
		// constant-speed mode masks detection while ramping
		det_gate = run_i && (!detect_timing_setting || (!accel_i && !decel_i));
		// over or under the quadrant level
		next_detect = det_gate &&
			(detect_polarity_setting ? (q_mag < q_level) : (q_mag > q_level));
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			limiting_active_output_o  <= 1'b0;
			torque_detect_output_o    <= 1'b0;
			torque_limit_o            <= `TLD_LIMIT_OFF;
			torque_estimate_monitor_o <= 9'h000;
		end else begin
			// active flag tracks the limit actually biting
			limiting_active_output_o  <= next_active;
			torque_detect_output_o    <= next_detect;
			torque_limit_o            <= (apply && q_limit != `TLD_LIMIT_OFF) ?
				q_limit : `TLD_LIMIT_OFF;
			torque_estimate_monitor_o <= torque_c;
		end
	end

	// route each output terminal by its function code
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			out_term_o <= 3'h0;
		end else begin
			for (int k = 0; k < 3; k++) begin
				out_term_o[k] <= (out_fn[k] == `TLD_FN_ACTIVE) ? next_active :
					(out_fn[k] == `TLD_FN_DETECT) ? next_detect : 1'b0;
			end
		end
	end

	// pause ramp-down briefly whenever limiting starts or stops
	always_ff @(posedge clk_i) begin
		if (srst_i || !decel_hold_setting) begin
			hold_cnt     <= 16'h0000;
			decel_hold_o <= 1'b0;
		end else if (decel_i && (next_active != limiting_active_output_o)) begin
			hold_cnt     <= `TLD_DECEL_HOLD_CYC - 16'h0001;
			decel_hold_o <= 1'b1;
		end else if (hold_cnt != 16'h0000) begin
			hold_cnt <= hold_cnt - 16'h0001;
		end else begin
			decel_hold_o <= 1'b0;
		end
	end

	// ---- checks ----
	logic [7:0] bits_pick;
	logic [1:0] quad_expect;
	logic [7:0] analog_expect;
	assign bits_pick     = limit_val[sel_idx];
	assign quad_expect   = {torque_c[8], speed_i[15] ^ torque_c[8]};
	assign analog_expect = 8'((18'(analog_voltage_input_i) * 18'(`TLD_PCT_MAX)) /
		`TLD_ANALOG_FS);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	a_always_limited: assert property (
		!le_assigned && speed_mode_i && q_limit != `TLD_LIMIT_OFF && q_mag >= q_limit
		|=> limiting_active_output_o)
		else $error("limit not active without enable terminal");
	a_enable_off: assert property (
		le_assigned && !le_level |=> !limiting_active_output_o &&
		torque_limit_o == `TLD_LIMIT_OFF)
		else $error("limit applied while enable terminal off");
	a_active_cause: assert property (
		limiting_active_output_o |-> $past(apply) && $past(q_mag) >= $past(q_limit))
		else $error("active flag without cause");
	a_out_route: assert property (
		out_fn[0] == `TLD_FN_ACTIVE && $stable(out_fn[0])
		|-> out_term_o[0] == limiting_active_output_o)
		else $error("output terminal not following active flag");
	a_bits_index: assert property (
		$past(src_q) == TLD_SRC_BITS && $stable(limit_val) |-> q_limit == $past(bits_pick))
		else $error("bit select picked wrong limit");
	a_quad_sign: assert property (
		##1 q_quad == $past(quad_expect))
		else $error("quadrant wrong for signs");
	a_analog_map: assert property (
		$past(src_q) == TLD_SRC_ANALOG |-> q_limit == $past(analog_expect))
		else $error("analog limit mapping wrong");
	a_detect_gate: assert property (
		detect_timing_setting && (accel_i || decel_i) |=> !torque_detect_output_o)
		else $error("detection not masked while ramping");
	a_detect_over: assert property (
		run_i && !detect_polarity_setting && !detect_timing_setting && q_mag > q_level
		|=> torque_detect_output_o)
		else $error("over-torque not flagged");
	a_monitor_pass: assert property (
		torque_est_i <= `TLD_TRQ_MAX && torque_est_i >= `TLD_TRQ_MIN
		|=> torque_estimate_monitor_o == $past(torque_c))
		else $error("monitor does not follow estimate");
	a_hold_length: assert property (
		$rose(decel_hold_o) |-> decel_hold_o [*8])
		else $error("deceleration hold too short");

endmodule

// ===== tb/tld_term_ctrl.sv
`timescale 1ns/1ps

// outside controller driving the multifunction input terminals
module tld_term_ctrl (
	// clock
	input  wire logic       clk_i,
	// commanded levels
	input  wire logic       lim_en_i,
	input  wire logic [1:0] sel_i,
	// terminals
	output logic [6:0]      in_term_o
);
	logic [3:0] spare;

	initial begin
		spare = 4'h5;
		in_term_o = 7'h00;
	end

	// levels change only after an edge and then hold
	// spare terminals keep toggling so an unassigned input never looks quiet
	always @(posedge clk_i) begin
		spare <= ~spare;
		in_term_o <= {spare, sel_i[1], sel_i[0], lim_en_i};
	end
endmodule

// ===== tb/torque_limit_and_torque_detect_bench.sv
`timescale 1ns/1ps
`include "tld_consts.svh"

module torque_limit_and_torque_detect_bench;
	logic               clk_i = 1'b0;
	logic               srst_i = 1'b1;
	logic [7:0]         awaddr = 8'h00;
	logic [7:0]         araddr = 8'h00;
	logic [31:0]        wdata = 32'h0;
	logic               awvalid = 1'b0;
	logic               wvalid = 1'b0;
	logic               bready = 1'b0;
	logic               arvalid = 1'b0;
	logic               rready = 1'b0;
	logic signed [9:0]  torque = 10'h000;
	logic signed [15:0] speed = 16'h0000;
	logic               run = 1'b1;
	logic               acc = 1'b0;
	logic               dec = 1'b0;
	logic               smode = 1'b1;
	logic               en_on = 1'b0;
	logic [1:0]         idx = 2'h0;
	logic [9:0]         an = 10'h000;
	logic [7:0]         opt = 8'h00;
	wire                awready, wready, bvalid, arready, rvalid, act, det, hold;
	wire [1:0]          bresp, rresp;
	wire [31:0]         rdata;
	wire [6:0]          in_term;
	wire [2:0]          out_term;
	wire [7:0]          tlim;
	wire signed [8:0]   mon;
	int                 mismatches = 0;
	int                 n_tests = 0;
	int                 seed = 2;
	logic [7:0]         lims [4];
	logic [7:0]         lvls [4];
	logic [1:0]         src = 2'h0;
	logic               pol = 1'b0;
	logic               tim = 1'b0;
	logic               hen = 1'b0;
	logic               en_asg = 1'b0;
	logic [31:0]        d;
	logic [1:0]         r;
	int                 n;

	always #25 clk_i = ~clk_i;

	tld_term_ctrl u_tld_term_ctrl (.clk_i(clk_i), .lim_en_i(en_on), .sel_i(idx), .in_term_o(in_term));

	tld_top u_tld_top (
		.clk_i(clk_i), .srst_i(srst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.in_term_i(in_term), .out_term_o(out_term),
		.torque_est_i(torque), .speed_i(speed), .run_i(run), .accel_i(acc), .decel_i(dec),
		.speed_mode_i(smode), .analog_voltage_input_i(an), .option_limit_i(opt),
		.limiting_active_output_o(act), .torque_detect_output_o(det), .decel_hold_o(hold),
		.torque_limit_o(tlim), .torque_estimate_monitor_o(mon)
	);

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge clk_i);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	task automatic cfg();
		logic [1:0] rs;
		axw(`TLD_ADDR_CTRL, {27'h0, tim, pol, hen, src}, rs);
		axw(`TLD_ADDR_LIMIT, {lims[3], lims[2], lims[1], lims[0]}, rs);
		axw(`TLD_ADDR_LEVEL, {lvls[3], lvls[2], lvls[1], lvls[0]}, rs);
		axw(`TLD_ADDR_INFN_LO, {8'h00, `TLD_FN_SEL_TWO, `TLD_FN_SEL_ONE,
			en_asg ? `TLD_FN_LIMIT_EN : 8'h00}, rs);
		chk("write response", 32'h0, {30'h0, rs});
	endtask

	function automatic logic [7:0] exp_lim(input logic [1:0] q);
		if (en_asg && !en_on) return 8'hFF;
		case (src)
			2'h0: return lims[q];
			2'h1: return lims[idx];
			2'h2: return 8'(int'(an) * 200 / 1023);
			default: return opt;
		endcase
	endfunction

	// quadrant follows the signs: q[1] torque negative, q[1]^q[0] speed negative
	task automatic go(input int mg, input logic [1:0] q);
		logic       lim_on, over;
		logic [7:0] e, m;
		@(posedge clk_i);
		torque <= 10'(q[1] ? -mg : mg);
		speed <= (q[1] ^ q[0]) ? -16'sd1000 : 16'sd1000;
		repeat (8) @(posedge clk_i);
		m = mg > 200 ? 8'hC8 : 8'(mg);
		e = exp_lim(q);
		lim_on = smode && e != 8'hFF && m >= e;
		over = run && !(tim && (acc || dec)) && (pol ? m < lvls[q] : m > lvls[q]);
		if (smode) chk("applied limit", e, tlim);
		chk("limiting active", lim_on, act);
		chk("torque detect", over, det);
		chk("output terminals", {1'b0, over, lim_on}, out_term);
		chk("torque monitor", q[1] ? -int'(m) : int'(m), mon);
	endtask

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk_i);
		mismatches++;
		report_and_stop();
	end

	initial begin
		repeat (10) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		axr(`TLD_ADDR_CTRL, d, r);
		chk("source reset", 32'h0, d);
		axr(`TLD_ADDR_LIMIT, d, r);
		chk("limit reset", 32'h96969696, d);
		axr(`TLD_ADDR_LEVEL, d, r);
		chk("level reset", 32'h64646464, d);
		axr(8'h1C, d, r);
		chk("unmapped read", 32'h2, {30'h0, r});
		axw(8'h1C, 32'hFFFFFFFF, r);
		chk("unmapped write", 32'h2, {30'h0, r});
		axw(`TLD_ADDR_STATUS, 32'hFFFFFFFF, r);
		chk("status write", 32'h0, {30'h0, r});
		axw(`TLD_ADDR_OUTFN, {16'h0, `TLD_FN_DETECT, `TLD_FN_ACTIVE}, r);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			lims[i] = 8'(1 + $unsigned($random(seed)) % 200);
			lvls[i] = 8'($unsigned($random(seed)) % 200);
		end
		// disable code in one quadrant
		lims[3] = 8'hFF;
		cfg();
		for (int q = 0; q < 4; q++)
			for (int k = 0; k < 2; k++)
				go(lims[q] == 8'hFF ? 150 : lims[q] - k, 2'(q));
		axr(`TLD_ADDR_STATUS, d, r);
		chk("status limit", exp_lim(2'h3), d[28:21]);
		$display("test quadrant limits done");
		en_asg = 1'b1;
		cfg();
		go(200, 2'h0);
		en_on <= 1'b1;
		go(200, 2'h1);
		smode <= 1'b0;
		go(200, 2'h0);
		smode <= 1'b1;
		$display("test limit enable done");
		src = 2'h1;
		cfg();
		for (int i = 0; i < 4; i++) begin
			idx <= 2'(i);
			go(200, 2'($random(seed)));
		end
		$display("test selected limit done");
		// nothing else is assigned to the analog input here
		src = 2'h2;
		cfg();
		for (int i = 0; i < 3; i++) begin
			an <= i == 0 ? 10'h000 : i == 1 ? 10'h3FF : 10'($random(seed));
			go(150, 2'($random(seed)));
		end
		src = 2'h3;
		cfg();
		opt <= 8'($unsigned($random(seed)) % 200);
		go(120, 2'h2);
		opt <= 8'hFF;
		go(120, 2'h3);
		$display("test analog and option done");
		src = 2'h0;
		en_on <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			pol = i[0];
			tim = i[1];
			for (int q = 0; q < 4; q++) lvls[q] = 8'($unsigned($random(seed)) % 200);
			cfg();
			acc <= i[2] & ~i[0];
			dec <= i[2] & i[0];
			for (int q = 0; q < 4; q++) go($unsigned($random(seed)) % 201, 2'(q));
		end
		run <= 1'b0;
		go(200, 2'h0);
		run <= 1'b1;
		go(300, 2'h0);
		go(511, 2'h2);
		$display("test torque detect done");
		en_asg = 1'b0;
		hen = 1'b1;
		tim = 1'b0;
		lims[0] = 8'h64;
		// no ramp while reconfiguring, or unassigning the limit-enable terminal itself retriggers the hold
		dec <= 1'b0;
		acc <= 1'b0;
		cfg();
		go(50, 2'h0);
		@(posedge clk_i);
		dec <= 1'b1;
		torque <= 10'sd150;
		n = 0;
		while (!hold && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		chk("hold raised", 32'h1, {31'h0, hold});
		n = 0;
		while (hold && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		chk("hold length", `TLD_DECEL_HOLD_CYC, n);
		hen = 1'b0;
		cfg();
		go(50, 2'h0);
		chk("hold off", 32'h0, {31'h0, hold});
		$display("test decel hold done");
		report_and_stop();
	end
endmodule
